// File: tb_tw_timer.sv
// Self-checking testbench of the waveform timer.
`timescale 1ns/1ps
module tb_tw_timer;
   // One scenario: registers, pin watched, expected high time and period (0 means still).
   typedef struct packed {
      logic [7:0] ca;
      logic [7:0] cb;
      logic [15:0] cap;
      logic [15:0] ma;
      logic [15:0] mb;
      logic pin;
      int hi;
      int per;
   } tw_case_t;
   // Reserved mode 13 is never programmed.
   localparam tw_case_t CASES [24] = '{
      '{8'h40, 8'h09, 16'h0, 16'h9, 16'h0, 1'b0, 10, 20},
      '{8'h40, 8'h0a, 16'h0, 16'h0, 16'h0, 1'b0, 8, 16},
      '{8'h40, 8'h0b, 16'h0, 16'h0, 16'h0, 1'b0, 64, 128},
      '{8'h40, 8'h0c, 16'h0, 16'h0, 16'h0, 1'b0, 256, 512},
      '{8'h40, 8'h0d, 16'h0, 16'h0, 16'h0, 1'b0, 1024, 2048},
      '{8'h40, 8'h0e, 16'h0, 16'h0, 16'h0, 1'b0, 20, 40},
      '{8'h40, 8'h0f, 16'h0, 16'h0, 16'h0, 1'b0, 20, 40},
      '{8'h20, 8'h09, 16'h0, 16'h9, 16'h3, 1'b1, 0, 0},
      '{8'h30, 8'h09, 16'h0, 16'h9, 16'h3, 1'b1, 1, 0},
      '{8'h40, 8'h19, 16'h9, 16'h0, 16'h0, 1'b0, 10, 20},
      '{8'h22, 8'h19, 16'h13, 16'h0, 16'h4, 1'b1, 5, 20},
      '{8'h32, 8'h19, 16'h13, 16'h0, 16'h4, 1'b1, 15, 20},
      '{8'h43, 8'h19, 16'h0, 16'h9, 16'h0, 1'b0, 10, 20},
      '{8'h12, 8'h19, 16'h13, 16'h0, 16'h4, 1'b1, 2, 0},
      '{8'h41, 8'h09, 16'h0, 16'h4, 16'h0, 1'b0, 2, 0},
      '{8'h22, 8'h19, 16'h13, 16'h0, 16'h13, 1'b1, 1, 0},
      '{8'h22, 8'h11, 16'ha, 16'ha, 16'h4, 1'b1, 8, 20},
      '{8'h43, 8'h11, 16'h0, 16'ha, 16'h0, 1'b0, 20, 40},
      '{8'h42, 8'h11, 16'ha, 16'h4, 16'h0, 1'b0, 2, 0},
      '{8'h30, 8'h11, 16'ha, 16'ha, 16'h4, 1'b1, 12, 20},
      '{8'h21, 8'h11, 16'h0, 16'ha, 16'h4, 1'b1, 8, 20},
      '{8'h21, 8'h01, 16'h0, 16'h0, 16'h4, 1'b1, 8, 510},
      '{8'h23, 8'h09, 16'h0, 16'h0, 16'h4, 1'b1, 5, 1024},
      '{8'h22, 8'h01, 16'h0, 16'h0, 16'h4, 1'b1, 8, 1022}};
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic ext_count_pin = 1'b0; // External count source, period 20 clocks.
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wave_pin_a;
   logic wave_pin_b;
   logic pin_override_a;
   logic pin_override_b;
   logic irq;
   logic pad_a; // Board level of pin a.
   int ext_div = 0;
   int err_count = 0;
   int tests_run = 0;
   tw_timer u_tw_timer (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
      .wave_pin_a(wave_pin_a), .wave_pin_b(wave_pin_b), .pin_override_a(pin_override_a),
      .pin_override_b(pin_override_b), .irq(irq));
   tw_pad_model u_tw_pad_model (.wave(wave_pin_a), .override(pin_override_a), .dir_out(1'b1),
      .port_level(1'b0), .pad(pad_a));
   // Clock of 10 ns and a free running external count square wave.
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      ext_div <= (ext_div == 9) ? 0 : ext_div + 1;
      if (ext_div == 9) ext_count_pin <= ~ext_count_pin;
   end
   // Prints the verdict and ends the run.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // One APB transfer: setup, then access held until pready at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Ends at the first rising edge that sees pready high; the timer ties pready high.
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   // Reads a register and checks data and error response.
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, x, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask : rdc
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask : tick
   function automatic logic pv(input logic b);
      return b ? wave_pin_b : wave_pin_a;
   endfunction : pv
   // Measures high time and full period of one pin from a rising edge.
   task automatic meas(input logic b, output int hi, output int per);
      int n;
      n = 0;
      while (pv(b) !== 1'b0 && n < 5000) begin tick(); n++; end
      while (pv(b) !== 1'b1 && n < 10000) begin tick(); n++; end
      hi = 0;
      while (pv(b) === 1'b1 && hi < 5000) begin tick(); hi++; end
      per = hi;
      while (pv(b) === 1'b0 && per < 10000) begin tick(); per++; end
   endtask : meas
   // Stops the counter, clears it and programs one scenario.
   task automatic cfg(input tw_case_t c);
      wr(tw_pkg::ADDR_CLK_CTRL, 32'h0);
      wr(tw_pkg::ADDR_COUNT, 32'h0);
      wr(tw_pkg::ADDR_OUT_MODE, {24'h0, c.ca});
      wr(tw_pkg::ADDR_CAPTURE, {16'h0, c.cap});
      wr(tw_pkg::ADDR_MATCH_A, {16'h0, c.ma});
      wr(tw_pkg::ADDR_MATCH_B, {16'h0, c.mb});
      wr(tw_pkg::ADDR_CLK_CTRL, {24'h0, c.cb});
   endtask : cfg
   // Watchdog well beyond the expected run length.
   initial begin
      #800us;
      err_count++;
      complete_run();
   end
   // Main sequence.
   initial begin
      tw_case_t c;
      logic [31:0] r;
      logic e;
      int hi;
      int per;
      int ch;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      tick();
      for (int i = 0; i < 8; i++) rdc("reset_value", 8'h80 + 8'(4 * i), 32'h0, 1'b0);
      rdc("unmapped", 8'ha0, 32'h0, 1'b1);
      wr(tw_pkg::ADDR_OUT_MODE, 32'hff);
      rdc("ctrl_a", tw_pkg::ADDR_OUT_MODE, 32'hf3, 1'b0);
      chk("override_b", 32'h1, {31'h0, pin_override_b});
      for (int i = 0; i < 24; i++) begin
         c = CASES[i];
         cfg(c);
         chk("override_a", {31'h0, c.ca[7:6] != 2'b00}, {31'h0, pin_override_a});
         chk("pad_a", {31'h0, (c.ca[7:6] != 2'b00) & wave_pin_a}, {31'h0, pad_a});
         repeat (600) tick();
         if (c.per == 0) begin
            e = pv(c.pin);
            ch = 0;
            repeat (300) begin tick(); ch += int'(pv(c.pin) !== e); end
            chk("still", 32'h0, 32'(ch));
            if (c.hi < 2) chk("level", 32'(c.hi), {31'h0, e});
         end else begin
            meas(c.pin, hi, per);
            chk("high_time", 32'(c.hi), 32'(hi));
            chk("period", 32'(c.per), 32'(per));
         end
         if (i == 0) begin
            apb(1'b0, tw_pkg::ADDR_IRQ_STATUS, 32'h0, r, e);
            chk("match_a_flag", 32'h1, {31'h0, r[tw_pkg::IRQ_MATCH_A]});
            chk("irq_masked", 32'h0, {31'h0, irq});
            wr(tw_pkg::ADDR_IRQ_MASK, 32'h1 << tw_pkg::IRQ_MATCH_A);
            chk("irq_on", 32'h1, {31'h0, irq});
            wr(tw_pkg::ADDR_CLK_CTRL, 32'h0);
            wr(tw_pkg::ADDR_IRQ_STATUS, 32'h7);
            rdc("status_clear", tw_pkg::ADDR_IRQ_STATUS, 32'h0, 1'b0);
            chk("irq_off", 32'h0, {31'h0, irq});
            wr(tw_pkg::ADDR_IRQ_MASK, 32'h0);
         end
      end
      complete_run();
   end
endmodule : tb_tw_timer

// File: tw_pad_model.sv
// Model of the board pad that a waveform pin drives.
`timescale 1ns/1ps
module tw_pad_model (
   input wire logic wave, // Waveform level from the timer.
   input wire logic override, // High while the timer owns the pin.
   input wire logic dir_out, // Direction bit, high for output.
   input wire logic port_level, // Level of normal port operation.
   output logic pad // Level seen on the board.
);
   // With the driver off a pull-up holds the pad high.
   assign pad = !dir_out ? 1'b1 : (override ? wave : port_level);
endmodule : tw_pad_model

// File: tw_pkg.sv
// Package with register map, field layouts, reset values and types of the 16-bit waveform timer.
package tw_pkg;
   // Register byte addresses on the APB bus.
   localparam logic [7:0] ADDR_OUT_MODE = 8'h80;
   localparam logic [7:0] ADDR_CLK_CTRL = 8'h84;
   localparam logic [7:0] ADDR_COUNT = 8'h88;
   localparam logic [7:0] ADDR_MATCH_A = 8'h8c;
   localparam logic [7:0] ADDR_MATCH_B = 8'h90;
   localparam logic [7:0] ADDR_CAPTURE = 8'h94;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h98;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h9c;
   // Values after reset.
   localparam logic [7:0] RST_OUT_MODE = 8'h00;
   localparam logic [4:0] RST_CLK_CTRL = 5'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [2:0] RST_IRQ = 3'h0;
   // Interrupt status bit positions.
   localparam int IRQ_OVF = 0;
   localparam int IRQ_MATCH_A = 1;
   localparam int IRQ_MATCH_B = 2;
   // Fixed top and bottom values.
   localparam logic [15:0] TOP_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] BOTTOM = 16'h0000;
   // Tick source select encodings.
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // Compare output action encodings.
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   // Layout of the output and mode control register.
   typedef struct packed {
      logic [1:0] compare_out_action_a;
      logic [1:0] compare_out_action_b;
      logic [1:0] reserved;
      logic [1:0] waveform_mode_low;
   } tw_out_mode_t;
   // Layout of the clock and capture control register (own layout, low five bits).
   typedef struct packed {
      logic [1:0] waveform_mode_high;
      logic [2:0] tick_source_select;
   } tw_clk_ctrl_t;
   // Count direction for the dual-slope modes, one bit so the code is trivially Gray.
   typedef enum logic {
      TW_DIR_UP = 1'b0,
      TW_DIR_DOWN = 1'b1
   } tw_dir_t;
endpackage : tw_pkg

// File: tw_timer.sv
// Top module of the 16-bit waveform timer with APB registers and two compare outputs.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module tw_timer (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count_pin,
   output logic wave_pin_a,
   output logic wave_pin_b,
   output logic pin_override_a,
   output logic pin_override_b,
   output logic irq
);
   // Software-visible registers.
   tw_pkg::tw_out_mode_t out_mode_q; // Compare actions and low mode bits.
   tw_pkg::tw_clk_ctrl_t clk_ctrl_q; // High mode bits and tick source.
   logic [15:0] count_value_q; // The counter itself.
   logic [15:0] match_buf_a_q; // Buffered compare value A as written.
   logic [15:0] match_buf_b_q; // Buffered compare value B as written.
   logic [15:0] match_value_a_q; // Active compare value A.
   logic [15:0] match_value_b_q; // Active compare value B.
   logic [15:0] capture_value_q; // Capture register, used as a top source.
   logic [2:0] irq_status_q; // Sticky event flags.
   logic [2:0] irq_mask_q; // Interrupt enables.
   logic [31:0] prdata_q; // Read data, captured in the setup cycle.
   // Internal state.
   tw_pkg::tw_dir_t dir_q; // Direction in the dual-slope modes.
   logic [9:0] prescale_q; // Free running prescaler.
   logic ext_meta_q; // First synchroniser stage of the external pin.
   logic ext_sync_q; // Second synchroniser stage.
   logic ext_prev_q; // Delayed copy for edge detection.
   logic wave_a_q; // Waveform output A.
   logic wave_b_q; // Waveform output B.
   logic block_q; // Suppresses the match after a counter write.
   // Combinational helpers.
   logic [3:0] mode; // Full waveform mode.
   logic non_pwm; // Normal or clear-on-match modes.
   logic fast_pwm; // Single-slope PWM modes.
   logic dual_pwm; // Dual-slope PWM modes.
   logic freq_correct; // Modes 8 and 9.
   logic clear_on_match_mode; // Clear-on-match modes.
   logic [15:0] top; // Selected top value.
   logic timer_tick; // One-cycle enable of the counter.
   logic at_top; // Counter at top.
   logic at_bottom; // Counter at bottom.
   logic hit_a; // Compare match A in this tick.
   logic hit_b; // Compare match B in this tick.
   logic load_buf; // Active compare values take the buffers.
   logic ovf_evt; // Overflow event in this tick.
   logic wr_en; // APB write access phase.
   logic rd_setup; // APB read setup cycle.
   logic mapped; // Address hits a register.
   logic [2:0] ovf_set; // Events in status layout.

   assign mode = {clk_ctrl_q.waveform_mode_high, out_mode_q.waveform_mode_low};
   // Writes to an address with nonzero upper bits are refused like any other unmapped write.
   assign wr_en = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;

   // Decode the mode into its family; the reserved code runs as normal mode.
   always_comb begin
      non_pwm = 1'b0;
      fast_pwm = 1'b0;
      dual_pwm = 1'b0;
      unique case (mode)
         4'd0, 4'd4, 4'd12, 4'd13: non_pwm = 1'b1;
         4'd5, 4'd6, 4'd7, 4'd14, 4'd15: fast_pwm = 1'b1;
         default: dual_pwm = 1'b1; // Modes 1 to 3 and 8 to 11.
      endcase
   end
   assign freq_correct = (mode == 4'd8) || (mode == 4'd9);
   assign clear_on_match_mode = (mode == 4'd4) || (mode == 4'd12);

   // Top value: a fixed width, compare register A or the capture register.
   always_comb begin
      unique case (mode)
         4'd1, 4'd5: top = tw_pkg::TOP_8BIT;
         4'd2, 4'd6: top = tw_pkg::TOP_9BIT;
         4'd3, 4'd7: top = tw_pkg::TOP_10BIT;
         4'd4, 4'd9, 4'd11, 4'd15: top = match_value_a_q;
         4'd8, 4'd10, 4'd12, 4'd14: top = capture_value_q;
         default: top = tw_pkg::TOP_MAX; // Modes 0 and 13.
      endcase
   end

   // Tick selection; the tick is an enable, never a clock.
   always_comb begin
      unique case (clk_ctrl_q.tick_source_select)
         tw_pkg::CS_STOP: timer_tick = 1'b0;
         tw_pkg::CS_DIV1: timer_tick = 1'b1;
         tw_pkg::CS_DIV8: timer_tick = &prescale_q[2:0];
         tw_pkg::CS_DIV64: timer_tick = &prescale_q[5:0];
         tw_pkg::CS_DIV256: timer_tick = &prescale_q[7:0];
         tw_pkg::CS_DIV1024: timer_tick = &prescale_q[9:0];
         tw_pkg::CS_EXT_FALL: timer_tick = ext_prev_q & ~ext_sync_q;
         tw_pkg::CS_EXT_RISE: timer_tick = ~ext_prev_q & ext_sync_q;
      endcase
   end

   // Prescaler and external pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prescale_q <= 10'h000;
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         prescale_q <= prescale_q + 10'h001;
         ext_meta_q <= ext_count_pin;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // Events of the current tick.
   assign at_top = (count_value_q == top);
   assign at_bottom = (count_value_q == tw_pkg::BOTTOM);
   assign hit_a = timer_tick & ~block_q & (count_value_q == match_value_a_q);
   assign hit_b = timer_tick & ~block_q & (count_value_q == match_value_b_q);
   always_comb begin
      if (non_pwm) begin
         load_buf = 1'b1; // Immediate update.
         ovf_evt = timer_tick & (count_value_q == tw_pkg::TOP_MAX);
      end else if (fast_pwm) begin
         load_buf = timer_tick & at_top; // Takes effect as the count wraps to bottom.
         ovf_evt = timer_tick & at_top;
      end else begin
         load_buf = timer_tick & (freq_correct ? at_bottom : at_top);
         ovf_evt = timer_tick & at_bottom & (dir_q == tw_pkg::TW_DIR_DOWN);
      end
   end

   // Counter and direction; software writes override the count.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_value_q <= tw_pkg::RST_WORD;
         dir_q <= tw_pkg::TW_DIR_UP;
         block_q <= 1'b0;
      end else if (wr_en && paddr[7:0] == tw_pkg::ADDR_COUNT) begin
         count_value_q <= pwdata[15:0];
         block_q <= 1'b1; // The next tick sees no match.
      end else if (timer_tick) begin
         block_q <= 1'b0;
         if (dual_pwm) begin
            if (dir_q == tw_pkg::TW_DIR_UP && at_top) begin
               dir_q <= tw_pkg::TW_DIR_DOWN;
               count_value_q <= count_value_q - 16'h0001;
            end else if (dir_q == tw_pkg::TW_DIR_DOWN && at_bottom) begin
               dir_q <= tw_pkg::TW_DIR_UP;
               count_value_q <= count_value_q + 16'h0001;
            end else if (dir_q == tw_pkg::TW_DIR_UP) begin
               count_value_q <= count_value_q + 16'h0001;
            end else begin
               count_value_q <= count_value_q - 16'h0001;
            end
         end else if ((clear_on_match_mode || fast_pwm) && at_top) begin
            dir_q <= tw_pkg::TW_DIR_UP;
            count_value_q <= tw_pkg::BOTTOM;
         end else begin
            dir_q <= tw_pkg::TW_DIR_UP;
            count_value_q <= count_value_q + 16'h0001;
         end
      end
   end

   // Next level of one waveform output for its action field, match and lane.
   function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic hit,
                                      input logic [15:0] cmp, input logic lane_a);
      logic r;
      r = cur;
      if (non_pwm) begin
         if (hit && com == tw_pkg::COM_TOGGLE) r = ~cur;
         if (hit && com == tw_pkg::COM_CLEAR) r = 1'b0;
         if (hit && com == tw_pkg::COM_SET) r = 1'b1;
      end else if (fast_pwm) begin
         if (com == tw_pkg::COM_TOGGLE) begin
            if (hit && lane_a && mode[3:1] == 3'h7) r = ~cur;
         end else if (com[1]) begin
            if (hit && cmp != top) r = (com == tw_pkg::COM_SET);
            if (timer_tick && at_top) r = (com == tw_pkg::COM_CLEAR); // Bottom action.
         end
      end else begin
         if (com == tw_pkg::COM_TOGGLE) begin
            if (hit && lane_a && (mode == 4'd9 || mode == 4'd11)) r = ~cur;
         end else if (com[1] && hit) begin
            r = (dir_q == tw_pkg::TW_DIR_UP) ? (com == tw_pkg::COM_SET)
                                             : (com == tw_pkg::COM_CLEAR);
         end
      end
      return r;
   endfunction : wave_next

   // Waveform outputs update on the tick only.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else if (timer_tick) begin
         wave_a_q <= wave_next(wave_a_q, out_mode_q.compare_out_action_a, hit_a,
                               match_value_a_q, 1'b1);
         wave_b_q <= wave_next(wave_b_q, out_mode_q.compare_out_action_b, hit_b,
                               match_value_b_q, 1'b0);
      end
   end
   assign wave_pin_a = wave_a_q;
   assign wave_pin_b = wave_b_q;
   // The pin driver also needs its direction bit set outside this block.
   assign pin_override_a = |out_mode_q.compare_out_action_a;
   assign pin_override_b = |out_mode_q.compare_out_action_b;

   // Control registers; reserved bits of control A are never stored.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         out_mode_q <= tw_pkg::RST_OUT_MODE;
         clk_ctrl_q <= tw_pkg::RST_CLK_CTRL;
         capture_value_q <= tw_pkg::RST_WORD;
         irq_mask_q <= tw_pkg::RST_IRQ;
      end else if (wr_en && pstrb[0]) begin
         unique case (paddr[7:0])
            tw_pkg::ADDR_OUT_MODE: out_mode_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
            tw_pkg::ADDR_CLK_CTRL: clk_ctrl_q <= pwdata[4:0];
            tw_pkg::ADDR_CAPTURE: capture_value_q <= pwdata[15:0];
            tw_pkg::ADDR_IRQ_MASK: irq_mask_q <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Compare buffers and their active copies.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         match_buf_a_q <= tw_pkg::RST_WORD;
         match_buf_b_q <= tw_pkg::RST_WORD;
         match_value_a_q <= tw_pkg::RST_WORD;
         match_value_b_q <= tw_pkg::RST_WORD;
      end else begin
         if (wr_en && paddr[7:0] == tw_pkg::ADDR_MATCH_A) match_buf_a_q <= pwdata[15:0];
         if (wr_en && paddr[7:0] == tw_pkg::ADDR_MATCH_B) match_buf_b_q <= pwdata[15:0];
         if (load_buf) begin
            match_value_a_q <= match_buf_a_q;
            match_value_b_q <= match_buf_b_q;
         end
      end
   end

   // Sticky flags: write one clears, a new event in the same cycle wins.
   assign ovf_set[tw_pkg::IRQ_OVF] = ovf_evt;
   assign ovf_set[tw_pkg::IRQ_MATCH_A] = hit_a;
   assign ovf_set[tw_pkg::IRQ_MATCH_B] = hit_b;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_status_q <= tw_pkg::RST_IRQ;
      end else if (wr_en && paddr[7:0] == tw_pkg::ADDR_IRQ_STATUS) begin
         irq_status_q <= (irq_status_q & ~pwdata[2:0]) | ovf_set;
      end else begin
         irq_status_q <= irq_status_q | ovf_set;
      end
   end
   assign irq = |(irq_status_q & irq_mask_q);

   // Read data is captured in the setup cycle and held through the access phase.
   assign mapped = (paddr[31:8] == 24'h000000) &&
                   (paddr[7:0] inside {tw_pkg::ADDR_OUT_MODE, tw_pkg::ADDR_CLK_CTRL,
                    tw_pkg::ADDR_COUNT, tw_pkg::ADDR_MATCH_A, tw_pkg::ADDR_MATCH_B,
                    tw_pkg::ADDR_CAPTURE, tw_pkg::ADDR_IRQ_STATUS, tw_pkg::ADDR_IRQ_MASK});
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h00000000;
      end else if (rd_setup) begin
         unique case (paddr[7:0])
            tw_pkg::ADDR_OUT_MODE: prdata_q <= {24'h000000, out_mode_q};
            tw_pkg::ADDR_CLK_CTRL: prdata_q <= {27'h0000000, clk_ctrl_q};
            tw_pkg::ADDR_COUNT: prdata_q <= {16'h0000, count_value_q};
            tw_pkg::ADDR_MATCH_A: prdata_q <= {16'h0000, match_buf_a_q};
            tw_pkg::ADDR_MATCH_B: prdata_q <= {16'h0000, match_buf_b_q};
            tw_pkg::ADDR_CAPTURE: prdata_q <= {16'h0000, capture_value_q};
            tw_pkg::ADDR_IRQ_STATUS: prdata_q <= {29'h00000000, irq_status_q};
            tw_pkg::ADDR_IRQ_MASK: prdata_q <= {29'h00000000, irq_mask_q};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
endmodule : tw_timer

// File: tw_timer_monitor.sv
// Checker of the waveform timer port behaviour, bound to the timer top.
`timescale 1ns/1ps
module tw_timer_monitor (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_count_pin,
   input wire logic wave_pin_a,
   input wire logic wave_pin_b,
   input wire logic pin_override_a,
   input wire logic pin_override_b,
   input wire logic irq
);
   // Bus write committed at this edge, and read in its access phase.
   wire logic wr = psel && penable && pwrite && pready;
   wire logic rd = psel && penable && !pwrite;
   logic [7:0] sa_q; // Shadow of control A as software left it.
   logic [4:0] sb_q; // Shadow of control B.
   logic [2:0] sm_q; // Shadow of the interrupt mask.
   wire logic stop = sb_q[2:0] == tw_pkg::CS_STOP;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // Shadows follow bus writes so outputs can be tied to what software programmed.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sa_q <= 8'h00;
         sb_q <= 5'h00;
         sm_q <= 3'h0;
      end else if (wr && pstrb[0]) begin
         if (paddr == {24'h0, tw_pkg::ADDR_OUT_MODE}) sa_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
         if (paddr == {24'h0, tw_pkg::ADDR_CLK_CTRL}) sb_q <= pwdata[4:0];
         if (paddr == {24'h0, tw_pkg::ADDR_IRQ_MASK}) sm_q <= pwdata[2:0];
      end
   end
   AST_OVR_A: assert property (pin_override_a == (sa_q[7:6] != 2'b00))
      else $error("override a differs from action a");
   AST_OVR_B: assert property (pin_override_b == (sa_q[5:4] != 2'b00))
      else $error("override b differs from action b");
   AST_CTRLA_ZERO: assert property (rd && paddr == 32'h80 |-> prdata[3:2] == 2'b00)
      else $error("control a bits 3 and 2 read nonzero");
   AST_CTRLA_READ: assert property (rd && paddr == 32'h80 |-> prdata == {24'h0, sa_q})
      else $error("control a readback wrong");
   AST_CTRLB_READ: assert property (rd && paddr == 32'h84 |-> prdata == {27'h0, sb_q})
      else $error("control b readback wrong");
   AST_WAVE_STOP: assert property (stop && $past(stop) && !wr && !$past(wr) |=>
      $stable(wave_pin_a) && $stable(wave_pin_b)) else $error("wave moved while stopped");
   AST_IRQ_STOP: assert property (stop && $past(stop) && !wr && !$past(wr) |=>
      $stable(irq)) else $error("flag set without a tick");
   AST_IRQ_MASK: assert property (sm_q == 3'h0 |-> !irq)
      else $error("irq high with all masked");
endmodule : tw_timer_monitor
bind tw_timer tw_timer_monitor u_tw_timer_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_count_pin(ext_count_pin), .wave_pin_a(wave_pin_a), .wave_pin_b(wave_pin_b),
   .pin_override_a(pin_override_a), .pin_override_b(pin_override_b), .irq(irq));
